// *** design/clk_sel_pkg.sv ***
package clk_sel_pkg;
    // =========================================
    // register map (byte addresses)
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    // control field positions
    localparam int F_FORCE_REF = 0;
    localparam int F_TX_HALF = 4;
    localparam int F_RX_HALF = 8;
    localparam int F_TX_SEL = 12;
    localparam int F_RX_SEL = 14;
    localparam int F_BYPASS = 16;
    localparam int F_PWR_DOWN = 18;
    localparam int F_ALIGN = 22;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // alignment modes per block
    localparam logic [1:0] ALIGN_INDEP = 2'h0;
    localparam logic [1:0] ALIGN_DUAL = 2'h1;
    localparam logic [1:0] ALIGN_QUAD = 2'h2;
    // =========================================
    // timing
    localparam int CLK_MHZ = 125;
    localparam int REF_LOCK_TIME_NS = 2000;
    localparam int DATA_TRY_TIME_NS = 4000;
    localparam int REF_CYC = (REF_LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int TRY_CYC = (DATA_TRY_TIME_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] REF_LAST = 16'(REF_CYC - 1);
    localparam logic [15:0] TRY_LAST = 16'(TRY_CYC - 1);
    // word clock level is msb of an 8-tick count (byte clock / 4)
    localparam int DIV_MSB = 2;
    typedef enum logic [1:0] {
        PLL_REF = 2'b01,
        PLL_DATA = 2'b10
    } pll_state_t;
endpackage

// *** design/serdes_core_clock_select.sv ***
// Notes on behaviour
// RULE1 - no data: cycle reference lock, data try
// RULE2 - per-channel bit forces reference lock
// RULE3 - word clock is quarter of deserializer rate
// RULE4 - per-channel half or full rate, tx/rx
// RULE5 - recovered and block clocks share rate
// RULE6 - tx word clock is byte clock / 4
// RULE7 - tx select: 0 channel C, 1 D
// RULE8 - rx select: 0 channel C, 1 D
// RULE9 - one rx word clock per block
// RULE10 - each channel outputs own recovered clock
// RULE11 - logic gives locked fifo read clock
// RULE12 - logic locks tx system clocks
// RULE13 - bypass: channel data on own clock
// RULE14 - bypass allows mixed rates, no fifo
// RULE15 - dual/quad align, power down independently
// RULE16 - dual: either recovered clock reads fifo
// RULE17 - quad: one block clock reads both
// RULE18 - same rate: both from tx clock
// RULE19 - mixed rate: one divided by two
// RULE20 - active-low reset clears alignment sync
// RULE21 - clock switch without short pulses
`timescale 1ns/100ps
`default_nettype none
module serdes_core_clock_select
    import clk_sel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] serdes_reference_clock,
    input wire logic [3:0] rx_data_tick,
    input wire logic [3:0] serial_rx_valid,
    input wire logic align_sync_reset_n,
    output logic [1:0] tx_block_word_clk,
    output logic [1:0] rx_block_word_clk,
    output logic [3:0] rx_recovered_word_clk,
    output logic [3:0] rx_locked_to_data,
    output logic [3:0] rx_fifo_available,
    output logic [1:0] align_active
);
    // =========================================
    // register bus
    logic [31:0] ctrl;
    logic [3:0] force_ref, tx_half, rx_half, power_down;
    logic [1:0] tx_clk_source_sel, rx_clk_source_sel, bypass;
    logic [1:0] tx_act_sel, rx_act_sel;
    logic [1:0] align_mode [2];
    logic access, wr_hit;
    pll_state_t pll_state [4];

    assign force_ref = ctrl[F_FORCE_REF +: 4];
    assign tx_half = ctrl[F_TX_HALF +: 4];
    assign rx_half = ctrl[F_RX_HALF +: 4];
    assign tx_clk_source_sel = ctrl[F_TX_SEL +: 2];
    assign rx_clk_source_sel = ctrl[F_RX_SEL +: 2];
    assign bypass = ctrl[F_BYPASS +: 2];
    assign power_down = ctrl[F_PWR_DOWN +: 4];
    assign align_mode[0] = ctrl[F_ALIGN +: 2];
    assign align_mode[1] = ctrl[F_ALIGN + 2 +: 2];
    assign access = psel && penable && !pready;
    assign wr_hit = psel && penable && pready && pwrite;

    function automatic logic [31:0] status_word();
        logic [31:0] s;
        s = 32'h0000_0000;
        for (int c = 0; c < 4; c++) begin
            s[c] = (pll_state[c] == PLL_DATA);
        end
        s[5:4] = ~bypass;
        s[7:6] = tx_act_sel;
        s[9:8] = rx_act_sel;
        return s;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access && paddr != CTRL_ADDR && paddr != STAT_ADDR;
            if (access && !pwrite) begin
                case (paddr)
                    CTRL_ADDR: prdata <= ctrl;
                    STAT_ADDR: prdata <= status_word();
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl <= CTRL_RESET;
        end else if (wr_hit && paddr == CTRL_ADDR) begin
            ctrl <= {6'h00, pwdata[25:0]};
        end
    end

    // =========================================
    // receive pll lock sequencing
    logic [15:0] pll_timer [4];

    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < 4; c++) begin
            if (reset || force_ref[c] || power_down[c]) begin
                // RULE2 forced reference lock
                pll_state[c] <= PLL_REF;
                pll_timer[c] <= 16'h0000;
            end else begin
                // RULE1 ref/data lock cycling
                case (pll_state[c])
                    PLL_REF: begin
                        if (pll_timer[c] == REF_LAST) begin
                            pll_state[c] <= PLL_DATA;
                            pll_timer[c] <= 16'h0000;
                        end else begin
                            pll_timer[c] <= pll_timer[c] + 16'h0001;
                        end
                    end
                    PLL_DATA: begin
                        if (serial_rx_valid[c]) begin
                            pll_timer[c] <= 16'h0000;
                        end else if (pll_timer[c] == TRY_LAST) begin
                            pll_state[c] <= PLL_REF;
                            pll_timer[c] <= 16'h0000;
                        end else begin
                            pll_timer[c] <= pll_timer[c] + 16'h0001;
                        end
                    end
                    default: begin
                        pll_state[c] <= PLL_REF;
                        pll_timer[c] <= 16'h0000;
                    end
                endcase
            end
        end
    end

    // =========================================
    // per-channel byte and word clock dividers
    logic [3:0] tx_pre, rx_pre;
    logic [2:0] tx_cnt [4];
    logic [2:0] rx_cnt [4];
    logic [3:0] tx_word, rx_word, rx_src_tick;

    always_comb begin
        for (int c = 0; c < 4; c++) begin
            tx_word[c] = tx_cnt[c][DIV_MSB];
            rx_word[c] = rx_cnt[c][DIV_MSB];
            // RULE13 recovered clock follows own data
            rx_src_tick[c] = (pll_state[c] == PLL_DATA) ? rx_data_tick[c]
                : serdes_reference_clock[c / 2];
        end
    end

    always_ff @(posedge clk_sys) begin
        for (int c = 0; c < 4; c++) begin
            if (reset || power_down[c]) begin
                // RULE15 powered-down channel stops alone
                tx_pre[c] <= 1'b0;
                rx_pre[c] <= 1'b0;
                tx_cnt[c] <= 3'h0;
                rx_cnt[c] <= 3'h0;
            end else begin
                // RULE4 half rate skips every other tick
                if (serdes_reference_clock[c / 2]) begin
                    tx_pre[c] <= !tx_pre[c];
                    // RULE6 byte clock divided by four
                    if (!tx_half[c] || tx_pre[c]) begin
                        tx_cnt[c] <= tx_cnt[c] + 3'h1;
                    end
                end
                // RULE3 word clock at quarter of byte rate
                if (rx_src_tick[c]) begin
                    rx_pre[c] <= !rx_pre[c];
                    if (!rx_half[c] || rx_pre[c]) begin
                        rx_cnt[c] <= rx_cnt[c] + 3'h1;
                    end
                end
            end
        end
    end

    // =========================================
    // block clock multiplexers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_act_sel <= 2'h0;
            rx_act_sel <= 2'h0;
            tx_block_word_clk <= 2'h0;
            rx_block_word_clk <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                // RULE21 switch only with old, new and output low
                if (!tx_block_word_clk[b]
                        && !tx_word[2 * b + tx_act_sel[b]]
                        && !tx_word[2 * b + tx_clk_source_sel[b]]) begin
                    tx_act_sel[b] <= tx_clk_source_sel[b];
                end
                if (!rx_block_word_clk[b]
                        && !rx_word[2 * b + rx_act_sel[b]]
                        && !rx_word[2 * b + rx_clk_source_sel[b]]) begin
                    rx_act_sel[b] <= rx_clk_source_sel[b];
                end
                // RULE7 tx source channel C or D
                tx_block_word_clk[b] <= tx_word[2 * b + tx_act_sel[b]];
                // RULE9 single rx clock per block
                // RULE8 rx source channel C or D
                rx_block_word_clk[b] <= rx_word[2 * b + rx_act_sel[b]];
            end
        end
    end

    // =========================================
    // channel outputs and alignment state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rx_recovered_word_clk <= 4'h0;
            rx_locked_to_data <= 4'h0;
            rx_fifo_available <= 4'h0;
            align_active <= 2'h0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                // RULE5 same rate as block clock
                // RULE10 own recovered word clock
                rx_recovered_word_clk[c] <= rx_word[c];
                rx_locked_to_data[c] <= (pll_state[c] == PLL_DATA);
                // RULE14 no alignment fifo in bypass
                rx_fifo_available[c] <= !bypass[c / 2] && !power_down[c];
            end
            for (int b = 0; b < 2; b++) begin
                // RULE20 alignment held in reset by logic
                align_active[b] <= align_sync_reset_n && !bypass[b]
                    && align_mode[b] != ALIGN_INDEP;
            end
        end
    end

    // =========================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_ref_to_data;
        pll_state[0] == PLL_REF && pll_timer[0] == REF_LAST
            && !force_ref[0] && !power_down[0] |=> pll_state[0] == PLL_DATA;
    endproperty
    a_ref_to_data: assert property (p_ref_to_data) // RULE1
        else $error("pll did not try data lock");

    property p_force_ref;
        force_ref[0] |=> pll_state[0] == PLL_REF ##1 !rx_locked_to_data[0];
    endproperty
    a_force_ref: assert property (p_force_ref) // RULE2
        else $error("forced pll left reference lock");

    property p_tx_mux;
        1 |=> tx_block_word_clk[0] == $past(tx_word[{1'b0, tx_act_sel[0]}]);
    endproperty
    a_tx_mux: assert property (p_tx_mux) // RULE7
        else $error("tx block clock not from active channel");

    property p_rx_mux;
        1 |=> rx_block_word_clk[1] == $past(rx_word[{1'b1, rx_act_sel[1]}]);
    endproperty
    a_rx_mux: assert property (p_rx_mux) // RULE8
        else $error("rx block clock not from active channel");

    property p_glitch_free;
        $changed(tx_act_sel[0]) |-> $past(tx_block_word_clk[0]) == 1'b0;
    endproperty
    a_glitch_free: assert property (p_glitch_free) // RULE21
        else $error("tx select changed while clock high");

    property p_half_rate;
        serdes_reference_clock[0] && tx_half[0] && !tx_pre[0]
            && !power_down[0] |=> $stable(tx_cnt[0]);
    endproperty
    a_half_rate: assert property (p_half_rate) // RULE4
        else $error("half rate divider advanced early");

    property p_recovered;
        1 |=> rx_recovered_word_clk[2] == $past(rx_cnt[2][DIV_MSB]);
    endproperty
    a_recovered: assert property (p_recovered) // RULE10
        else $error("recovered word clock mismatch");

    property p_power_down;
        power_down[1] [*3] |-> !rx_recovered_word_clk[1] && !tx_word[1];
    endproperty
    a_power_down: assert property (p_power_down) // RULE15
        else $error("powered-down channel still clocking");

    property p_bypass;
        bypass[0] |=> rx_fifo_available[1:0] == 2'h0;
    endproperty
    a_bypass: assert property (p_bypass) // RULE14
        else $error("fifo available in bypass mode");

    c_data_lock: cover property (pll_state[0] == PLL_DATA
        && serial_rx_valid[0]);
    c_retry: cover property (pll_state[0] == PLL_DATA
        ##1 pll_state[0] == PLL_REF);
    c_tx_switch: cover property ($changed(tx_act_sel[0]));
    c_quad: cover property (align_active == 2'h3);
endmodule
`default_nettype wire

// *** bench/fabric_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module fabric_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic valid_en,
    input wire logic align_hold,
    input wire logic mixed_tx,
    input wire logic quad,
    input wire logic [1:0] tx_word_clk,
    input wire logic [1:0] rx_word_clk,
    input wire logic [3:0] rec_clk,
    output logic [1:0] ref_tick,
    output logic [3:0] data_tick,
    output logic [3:0] rx_valid,
    output logic align_rst_n,
    output logic [3:0] tx_sys_clk,
    output logic [1:0] fifo_rd_clk
);
    logic [1:0] tx_prev, tx_div2;
    assign ref_tick = 2'b11;
    assign data_tick = 4'hf;
    assign rx_valid = {4{valid_en}};
    always_ff @(posedge clk_sys) begin
        align_rst_n <= !(reset || align_hold);
    end
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_prev <= 2'h0;
            tx_div2 <= 2'h0;
        end else begin
            tx_prev <= tx_word_clk;
            // halve tx word clock in logic
            tx_div2 <= tx_div2 ^ (tx_word_clk & ~tx_prev);
        end
    end
    // channel C from block tx clock
    assign tx_sys_clk = {mixed_tx ? tx_div2[1] : tx_word_clk[1],
        tx_word_clk[1], mixed_tx ? tx_div2[0] : tx_word_clk[0],
        tx_word_clk[0]};
    // dual: channel C recovered clock reads fifo
    // quad: block A rx clock reads both
    // read clock locked to write clock
    assign fifo_rd_clk = quad ? {2{rx_word_clk[0]}}
        : {rec_clk[2], rec_clk[0]};
endmodule
`default_nettype wire

// *** bench/tb_serdes_core_clock_select.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_serdes_core_clock_select;
import clk_sel_pkg::*;
logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic pready, pslverr, er, align_rst_n, valid_en = 0, align_hold = 0;
logic [1:0] ref_tick, txw, rxw, align_act;
logic [3:0] data_tick, rx_valid, recw, locked, fifo_av;
logic [13:0] mon;
logic [3:0] tx_sys;
logic [1:0] fifo_rd;
logic mixed_tx = 0, quad = 0;
int errors = 0, samples_checked = 0, cyc = 0, n;
assign mon = {fifo_rd, tx_sys, recw, rxw, txw};
initial forever #4 clk_sys = ~clk_sys;
fabric_model i_fabric_model (.clk_sys(clk_sys), .reset(reset),
    .valid_en(valid_en), .align_hold(align_hold), .mixed_tx(mixed_tx),
    .quad(quad), .tx_word_clk(txw), .rx_word_clk(rxw), .rec_clk(recw),
    .ref_tick(ref_tick), .data_tick(data_tick), .rx_valid(rx_valid),
    .align_rst_n(align_rst_n), .tx_sys_clk(tx_sys), .fifo_rd_clk(fifo_rd));
serdes_core_clock_select i_serdes_core_clock_select (.clk_sys(clk_sys),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serdes_reference_clock(ref_tick),
    .rx_data_tick(data_tick), .serial_rx_valid(rx_valid),
    .align_sync_reset_n(align_rst_n), .tx_block_word_clk(txw),
    .rx_block_word_clk(rxw), .rx_recovered_word_clk(recw),
    .rx_locked_to_data(locked), .rx_fifo_available(fifo_av),
    .align_active(align_act));
// ==========================================
// tasks
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
        errors++;
        $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge clk_sys);
    penable <= 1;
    do begin
        @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task automatic wait_lock(input logic [3:0] want);
    n = 0;
    while (locked !== want && n < 2000) begin
        @(posedge clk_sys);
        n++;
    end
endtask
// counts rising edges over 160 cycles, one edge of slack
task automatic rate(input string nm, input int idx, input int e);
    int k;
    logic p;
    k = 0;
    p = mon[idx];
    repeat (160) begin
        @(posedge clk_sys);
        if (mon[idx] === 1'b1 && p === 1'b0) k++;
        p = mon[idx];
    end
    chk(nm, (k >= e - 1 && k <= e + 1) ? 32'(e) : 32'(k), 32'(e));
endtask
// ==========================================
// hang guard
always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 12000) begin
        errors++;
        tally_and_finish();
    end
end
// ==========================================
// main sequence
initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 0;
    wait_lock(4'hf);
    chk("ref_lock_time", (n >= REF_CYC - 2 && n <= REF_CYC + 3) ?
        32'(REF_CYC) : 32'(n), 32'(REF_CYC));
    wait_lock(4'h0);
    chk("data_try_time", (n >= TRY_CYC - 2 && n <= TRY_CYC + 3) ?
        32'(TRY_CYC) : 32'(n), 32'(TRY_CYC));
    valid_en <= 1;
    apb(1, CTRL_ADDR, 32'h0000_0001);
    wait_lock(4'he);
    repeat (600) @(posedge clk_sys);
    chk("forced_ref", 32'(locked), 32'he);
    apb(0, STAT_ADDR, 32'h0);
    chk("stat_lock", rd, 32'h0000_003e);
    mixed_tx <= 1;
    apb(1, CTRL_ADDR, 32'h0000_523f);
    repeat (40) @(posedge clk_sys);
    rate("tx_a_from_d_half", 0, 10);
    rate("tx_b_from_c_full", 1, 20);
    rate("rx_a_from_d_half", 2, 10);
    rate("rx_b_from_c_full", 3, 20);
    rate("recovered_ch0", 4, 20);
    rate("tx_sys_c_word", 8, 10);
    rate("tx_sys_d_div2", 9, 5);
    apb(0, STAT_ADDR, 32'h0);
    chk("stat_selects", rd, 32'h0000_0170);
    mixed_tx <= 0;
    apb(1, CTRL_ADDR, 32'h0000_020f);
    repeat (40) @(posedge clk_sys);
    rate("tx_a_from_c", 0, 20);
    rate("rx_a_from_c", 2, 20);
    rate("recovered_ch1_half", 5, 10);
    rate("tx_sys_b_same", 11, 20);
    rate("fifo_rd_dual_a", 12, 20);
    quad <= 1;
    repeat (4) @(posedge clk_sys);
    rate("fifo_rd_quad_b", 13, 20);
    apb(1, CTRL_ADDR, 32'h0111_0000);
    repeat (3) @(posedge clk_sys);
    chk("fifo_avail", 32'(fifo_av), 32'h8);
    chk("align_dual_b", 32'(align_act), 32'h2);
    align_hold <= 1;
    repeat (4) @(posedge clk_sys);
    chk("align_held", 32'(align_act), 32'h0);
    apb(1, CTRL_ADDR, 32'hffff_ffff);
    apb(0, CTRL_ADDR, 32'h0);
    chk("ctrl_readback", rd, 32'h03ff_ffff);
    apb(0, 8'h08, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    chk("unmapped_data", rd, 32'h0);
    tally_and_finish();
end
endmodule
`default_nettype wire
